// ===== common/pss_pkg.sv
// Package for the position step sequencer: register offsets, field layout,
// reset values and timing counts.
// Assumes a 40 MHz clock and a plain strobe register port.
`default_nettype none
package pss_pkg;
   // ------------------------------------------------------------
   // Register offsets (word index on the plain port)
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_GROUP_TYPE = 4'h0;
   localparam logic [3:0] OFF_POS_LOW = 4'h1;
   localparam logic [3:0] OFF_POS_HIGH = 4'h2;
   localparam logic [3:0] OFF_SPEED = 4'h3;
   localparam logic [3:0] OFF_STEP_PROP = 4'h4;
   localparam logic [3:0] OFF_COND1_VAL = 4'h5;
   localparam logic [3:0] OFF_COND2_VAL = 4'h6;
   localparam logic [3:0] OFF_CONTROL = 4'h7;
   localparam logic [3:0] OFF_STATUS = 4'h8;
   localparam logic [3:0] OFF_TARGET_LO = 4'h9;
   localparam logic [3:0] OFF_TARGET_HI = 4'ha;
   // ------------------------------------------------------------
   // Limits and reset values
   // ------------------------------------------------------------
   localparam logic signed [15:0] POS_PART_MAX = 16'sd9999;
   localparam logic signed [15:0] POS_PART_MIN = -16'sd9999;
   localparam logic signed [31:0] POS_HIGH_WEIGHT = 32'sd10000;
   localparam logic [15:0] SPEED_MAX = 16'h1770;
   localparam logic [15:0] SPEED_RESET = 16'h0064;
   localparam logic [15:0] PROP_RESET = 16'h0000;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // ------------------------------------------------------------
   // Step property digits, one nibble each: cond1, cond2, join, mode
   // ------------------------------------------------------------
   localparam int PROP_COND1_LSB = 0;
   localparam int PROP_COND2_LSB = 4;
   localparam int PROP_JOIN_LSB = 8;
   localparam int PROP_MODE_LSB = 12;
   localparam logic [3:0] COND_UNCOND = 4'h0;
   localparam logic [3:0] COND_DELAY = 4'h1;
   localparam logic [3:0] COND_EDGE = 4'h2;
   localparam logic [3:0] COND_LEVEL = 4'h3;
   localparam logic [3:0] JOIN_NONE = 4'h0;
   localparam logic [3:0] JOIN_AND = 4'h1;
   localparam logic [3:0] JOIN_OR = 4'h2;
   localparam logic [1:0] GT_INVALID = 2'h0;
   localparam logic [1:0] GT_ABSOLUTE = 2'h1;
   localparam logic [1:0] GT_RELATIVE = 2'h2;
   localparam logic [15:0] EDGE_RISE = 16'h0000;
   localparam logic [15:0] EDGE_FALL = 16'h0001;
   localparam logic [15:0] EDGE_BOTH = 16'h0002;
   localparam logic [15:0] LEVEL_HIGH = 16'h0003;
   localparam logic [15:0] LEVEL_LOW = 16'h0004;
   // ------------------------------------------------------------
   // Timing: one delay unit is one millisecond
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int DELAY_UNIT_US = 1000;
   localparam int DELAY_UNIT_CYC = CLK_HZ / 1000000 * DELAY_UNIT_US;
   // Control register bits
   localparam int CTL_RESTART = 0;
   localparam int CTL_START = 1;
   localparam int CTL_MOTION_DONE = 2;
endpackage
`default_nettype wire

// ===== common/pss_cond_if.sv
// Interface carrying one step condition from the sequencer to its evaluator.
// Assumes both ends run on the same clock.
`default_nettype none
interface pss_cond_if;
   logic [3:0] kind;
   logic [15:0] value;
   logic arm;
   logic met;
   modport seq(output kind, output value, output arm, input met);
   modport eval(input kind, input value, input arm, output met);
endinterface
`default_nettype wire

// ===== rtl/pss_cond_eval.sv
// Evaluates one step condition: unconditional, delay, edge or level.
// Assumes step input is already synchronised and edges are pulses on clk.
`default_nettype none
module pss_cond_eval #(
   parameter int UNIT_CYC = pss_pkg::DELAY_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Synchronised step input and its edges
   input wire logic step_lvl,
   input wire logic step_rise,
   input wire logic step_fall,
   // Condition
   pss_cond_if.eval cif
);
   logic [31:0] unit_reg, unit_next;
   logic [15:0] cnt_reg, cnt_next;
   logic met_reg, met_next;

   // ------------------------------------------------------------
   // Condition evaluation
   // ------------------------------------------------------------
   // Delay counts whole units; an edge latches until disarmed so it is not lost
   always_comb begin
      unit_next = unit_reg;
      cnt_next = cnt_reg;
      met_next = met_reg;
      if (!cif.arm) begin
         unit_next = 32'h0;
         cnt_next = 16'h0;
         met_next = 1'b0;
      end else begin
         unique case (cif.kind)
            pss_pkg::COND_UNCOND: met_next = 1'b1;
            pss_pkg::COND_DELAY: begin
               if (cnt_reg >= cif.value) begin
                  met_next = 1'b1;
               end else if (unit_reg == 32'(UNIT_CYC - 1)) begin
                  unit_next = 32'h0;
                  cnt_next = cnt_reg + 16'h1;
               end else begin
                  unit_next = unit_reg + 32'h1;
               end
            end
            pss_pkg::COND_EDGE: begin
               if ((cif.value == pss_pkg::EDGE_RISE && step_rise) ||
                   (cif.value == pss_pkg::EDGE_FALL && step_fall) ||
                   (cif.value == pss_pkg::EDGE_BOTH && (step_rise || step_fall))) begin
                  met_next = 1'b1;
               end
            end
            pss_pkg::COND_LEVEL: begin
               met_next = (cif.value == pss_pkg::LEVEL_HIGH && step_lvl) ||
                          (cif.value == pss_pkg::LEVEL_LOW && !step_lvl);
            end
            default: met_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         unit_reg <= 32'h0;
         cnt_reg <= 16'h0;
         met_reg <= 1'b0;
      end else begin
         unit_reg <= unit_next;
         cnt_reg <= cnt_next;
         met_reg <= met_next;
      end
   end

   assign cif.met = met_reg;

   a_uncond_met: assert property (@(posedge clk) disable iff (!rstn)
      cif.arm && $past(cif.arm) && cif.kind == pss_pkg::COND_UNCOND |=> met_reg)
      else $error("unconditional step not met");
   a_edge_rise: assert property (@(posedge clk) disable iff (!rstn)
      cif.arm && cif.kind == pss_pkg::COND_EDGE && cif.value == pss_pkg::EDGE_RISE && step_rise
      |=> met_reg)
      else $error("rising edge not caught");
   a_level_high: assert property (@(posedge clk) disable iff (!rstn)
      cif.arm && cif.kind == pss_pkg::COND_LEVEL && cif.value == pss_pkg::LEVEL_HIGH ##1
      cif.arm && cif.kind == pss_pkg::COND_LEVEL |-> met_reg == $past(step_lvl))
      else $error("level condition wrong");
   a_delay_early: assert property (@(posedge clk) disable iff (!rstn)
      cif.arm && cif.kind == pss_pkg::COND_DELAY && cnt_reg < cif.value |=> !met_reg)
      else $error("delay met early");
endmodule
`default_nettype wire

// ===== rtl/pss_seq_top.sv
// Position step sequencer for the second table entry.
// Assumes a plain strobe register port on clk and an asynchronous step pin.
// What this block does
// - Low position, signed, clamped to +-9999, resets 0
// - High position weighs 10000; target combines both parts
// - Speed 1 rpm steps, 0-6000, default 100
// - Four-digit step property, default 0000, restart-effective
// - Delay condition waits value units then advances
// - Edge condition: 0 rise, 1 fall, 2 both
// - Level condition: 3 high, 4 low
// - Group type: 0 invalid, 1 absolute, 2 relative
//
// The strobed register port and the address map were chosen for this implementation.
`default_nettype none
module pss_seq_top #(
   parameter int UNIT_CYC = pss_pkg::DELAY_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Step pin
   input wire logic position_step_input,
   // Motion handoff
   output logic entry_active,
   output logic entry_absolute,
   output logic signed [31:0] entry_target,
   output logic [15:0] entry_speed,
   output logic [3:0] entry_mode,
   output logic step_advance
);
   typedef enum logic [2:0] {
      PSS_IDLE = 3'b001,
      PSS_MOVE = 3'b010,
      PSS_WAIT = 3'b100
   } pss_state_e;

   // Shadow registers written by software; active copies loaded on restart
   logic [1:0] gt_sh_reg, gt_sh_next, gt_reg, gt_next;
   logic signed [15:0] lo_sh_reg, lo_sh_next, lo_reg, lo_next;
   logic signed [15:0] hi_sh_reg, hi_sh_next, hi_reg, hi_next;
   logic [15:0] spd_sh_reg, spd_sh_next, spd_reg, spd_next;
   logic [15:0] prop_sh_reg, prop_sh_next, prop_reg, prop_next;
   logic [15:0] v1_sh_reg, v1_sh_next, v1_reg, v1_next;
   logic [15:0] v2_sh_reg, v2_sh_next, v2_reg, v2_next;
   logic [31:0] rdata_reg, rdata_next;
   logic signed [31:0] tgt_reg, tgt_next;
   logic adv_reg, adv_next;
   logic done_reg, done_next;
   logic act_reg, act_next, abs_reg, abs_next;
   pss_state_e st_reg, st_next;
   logic [2:0] sync_reg;
   logic step_rise, step_fall;
   logic cond_ok;
   logic signed [15:0] wd16;
   pss_cond_if c1 ();
   pss_cond_if c2 ();

   // ------------------------------------------------------------
   // Step pin synchroniser
   // ------------------------------------------------------------
   // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_reg <= 3'b000;
      end else begin
         sync_reg <= {sync_reg[1:0], position_step_input};
      end
   end
   assign step_rise = sync_reg[1] && !sync_reg[2];
   assign step_fall = !sync_reg[1] && sync_reg[2];

   // ------------------------------------------------------------
   // Condition evaluators
   // ------------------------------------------------------------
   pss_cond_eval #(.UNIT_CYC(UNIT_CYC)) u_c1 (
      .clk(clk), .rstn(rstn), .step_lvl(sync_reg[1]),
      .step_rise(step_rise), .step_fall(step_fall), .cif(c1));
   pss_cond_eval #(.UNIT_CYC(UNIT_CYC)) u_c2 (
      .clk(clk), .rstn(rstn), .step_lvl(sync_reg[1]),
      .step_rise(step_rise), .step_fall(step_fall), .cif(c2));

   assign c1.kind = prop_reg[pss_pkg::PROP_COND1_LSB +: 4];
   assign c2.kind = prop_reg[pss_pkg::PROP_COND2_LSB +: 4];
   assign c1.value = v1_reg;
   assign c2.value = v2_reg;
   assign c1.arm = (st_reg == PSS_WAIT);
   assign c2.arm = (st_reg == PSS_WAIT);

   // Join of the two conditions; with no join only the first counts
   always_comb begin
      unique case (prop_reg[pss_pkg::PROP_JOIN_LSB +: 4])
         pss_pkg::JOIN_AND: cond_ok = c1.met && c2.met;
         pss_pkg::JOIN_OR: cond_ok = c1.met || c2.met;
         default: cond_ok = c1.met;
      endcase
   end

   // ------------------------------------------------------------
   // Register writes and restart
   // ------------------------------------------------------------
   // Writes land in shadows; nothing reaches the motion side until restart
   always_comb begin
      wd16 = reg_wdata[15:0];
      gt_sh_next = gt_sh_reg;
      lo_sh_next = lo_sh_reg;
      hi_sh_next = hi_sh_reg;
      spd_sh_next = spd_sh_reg;
      prop_sh_next = prop_sh_reg;
      v1_sh_next = v1_sh_reg;
      v2_sh_next = v2_sh_reg;
      gt_next = gt_reg;
      lo_next = lo_reg;
      hi_next = hi_reg;
      spd_next = spd_reg;
      prop_next = prop_reg;
      v1_next = v1_reg;
      v2_next = v2_reg;
      if (reg_wr) begin
         unique case (reg_addr)
            pss_pkg::OFF_GROUP_TYPE: gt_sh_next = reg_wdata[1:0];
            pss_pkg::OFF_POS_LOW: lo_sh_next = (wd16 > pss_pkg::POS_PART_MAX) ? pss_pkg::POS_PART_MAX :
               (wd16 < pss_pkg::POS_PART_MIN) ? pss_pkg::POS_PART_MIN : wd16;
            pss_pkg::OFF_POS_HIGH: hi_sh_next = (wd16 > pss_pkg::POS_PART_MAX) ? pss_pkg::POS_PART_MAX :
               (wd16 < pss_pkg::POS_PART_MIN) ? pss_pkg::POS_PART_MIN : wd16;
            pss_pkg::OFF_SPEED: spd_sh_next = (reg_wdata[15:0] > pss_pkg::SPEED_MAX) ?
               pss_pkg::SPEED_MAX : reg_wdata[15:0];
            pss_pkg::OFF_STEP_PROP: prop_sh_next = reg_wdata[15:0];
            pss_pkg::OFF_COND1_VAL: v1_sh_next = reg_wdata[15:0];
            pss_pkg::OFF_COND2_VAL: v2_sh_next = reg_wdata[15:0];
            pss_pkg::OFF_CONTROL: begin
               if (reg_wdata[pss_pkg::CTL_RESTART]) begin
                  gt_next = gt_sh_reg;
                  lo_next = lo_sh_reg;
                  hi_next = hi_sh_reg;
                  spd_next = spd_sh_reg;
                  prop_next = prop_sh_reg;
                  v1_next = v1_sh_reg;
                  v2_next = v2_sh_reg;
               end
            end
            default: ;
         endcase
      end
      abs_next = (gt_next == pss_pkg::GT_ABSOLUTE);
   end

   // Target combines the two parts; relative mode leaves the sum to the profiler
   assign tgt_next = 32'(hi_reg) * pss_pkg::POS_HIGH_WEIGHT + 32'(lo_reg);

   // ------------------------------------------------------------
   // Step sequencer
   // ------------------------------------------------------------
   // A motion done that arrives while a start is issued is kept, not dropped
   always_comb begin
      st_next = st_reg;
      adv_next = 1'b0;
      done_next = done_reg;
      if (reg_wr && reg_addr == pss_pkg::OFF_CONTROL && reg_wdata[pss_pkg::CTL_MOTION_DONE]) begin
         done_next = 1'b1;
      end
      unique case (st_reg)
         PSS_IDLE: begin
            if (reg_wr && reg_addr == pss_pkg::OFF_CONTROL && reg_wdata[pss_pkg::CTL_START] &&
                gt_reg != pss_pkg::GT_INVALID) begin
               st_next = PSS_MOVE;
               done_next = reg_wdata[pss_pkg::CTL_MOTION_DONE];
            end
         end
         PSS_MOVE: begin
            if (done_reg) begin
               st_next = PSS_WAIT;
            end
         end
         PSS_WAIT: begin
            if (cond_ok) begin
               st_next = PSS_IDLE;
               adv_next = 1'b1;
            end
         end
         default: st_next = PSS_IDLE;
      endcase
      // Registered copy so the output needs no decode after the flop
      act_next = (st_next != PSS_IDLE);
   end

   // Read mux: configuration shadows plus live state
   always_comb begin
      rdata_next = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            pss_pkg::OFF_GROUP_TYPE: rdata_next = {30'h0, gt_sh_reg};
            pss_pkg::OFF_POS_LOW: rdata_next = 32'(lo_sh_reg);
            pss_pkg::OFF_POS_HIGH: rdata_next = 32'(hi_sh_reg);
            pss_pkg::OFF_SPEED: rdata_next = {16'h0, spd_sh_reg};
            pss_pkg::OFF_STEP_PROP: rdata_next = {16'h0, prop_sh_reg};
            pss_pkg::OFF_COND1_VAL: rdata_next = {16'h0, v1_sh_reg};
            pss_pkg::OFF_COND2_VAL: rdata_next = {16'h0, v2_sh_reg};
            pss_pkg::OFF_STATUS: rdata_next = {25'h0, sync_reg[1], c2.met, c1.met, done_reg, st_reg};
            pss_pkg::OFF_TARGET_LO: rdata_next = {16'h0, tgt_reg[15:0]};
            pss_pkg::OFF_TARGET_HI: rdata_next = {16'h0, tgt_reg[31:16]};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         gt_sh_reg <= pss_pkg::GT_INVALID;
         lo_sh_reg <= pss_pkg::ZERO16;
         hi_sh_reg <= pss_pkg::ZERO16;
         spd_sh_reg <= pss_pkg::SPEED_RESET;
         prop_sh_reg <= pss_pkg::PROP_RESET;
         v1_sh_reg <= pss_pkg::ZERO16;
         v2_sh_reg <= pss_pkg::ZERO16;
         gt_reg <= pss_pkg::GT_INVALID;
         lo_reg <= pss_pkg::ZERO16;
         hi_reg <= pss_pkg::ZERO16;
         spd_reg <= pss_pkg::SPEED_RESET;
         prop_reg <= pss_pkg::PROP_RESET;
         v1_reg <= pss_pkg::ZERO16;
         v2_reg <= pss_pkg::ZERO16;
         rdata_reg <= 32'h0;
         tgt_reg <= 32'sh0;
         adv_reg <= 1'b0;
         done_reg <= 1'b0;
         st_reg <= PSS_IDLE;
         act_reg <= 1'b0;
         abs_reg <= 1'b0;
      end else begin
         gt_sh_reg <= gt_sh_next;
         lo_sh_reg <= lo_sh_next;
         hi_sh_reg <= hi_sh_next;
         spd_sh_reg <= spd_sh_next;
         prop_sh_reg <= prop_sh_next;
         v1_sh_reg <= v1_sh_next;
         v2_sh_reg <= v2_sh_next;
         gt_reg <= gt_next;
         lo_reg <= lo_next;
         hi_reg <= hi_next;
         spd_reg <= spd_next;
         prop_reg <= prop_next;
         v1_reg <= v1_next;
         v2_reg <= v2_next;
         rdata_reg <= rdata_next;
         tgt_reg <= tgt_next;
         adv_reg <= adv_next;
         done_reg <= done_next;
         st_reg <= st_next;
         act_reg <= act_next;
         abs_reg <= abs_next;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_reg;
   assign entry_active = act_reg;
   assign entry_absolute = abs_reg;
   assign entry_target = tgt_reg;
   assign entry_speed = spd_reg;
   assign entry_mode = prop_reg[pss_pkg::PROP_MODE_LSB +: 4];
   assign step_advance = adv_reg;

   a_low_clamped: assert property (@(posedge clk) disable iff (!rstn)
      lo_sh_reg <= pss_pkg::POS_PART_MAX && lo_sh_reg >= pss_pkg::POS_PART_MIN)
      else $error("low position out of range");
   a_target_sum: assert property (@(posedge clk) disable iff (!rstn)
      ##1 tgt_reg == $past(32'(hi_reg)) * 32'sd10000 + $past(32'(lo_reg)))
      else $error("target mismatch");
   a_speed_limit: assert property (@(posedge clk) disable iff (!rstn)
      spd_sh_reg <= 16'h1770)
      else $error("speed over limit");
   a_prop_restart: assert property (@(posedge clk) disable iff (!rstn)
      !(reg_wr && reg_addr == pss_pkg::OFF_CONTROL && reg_wdata[pss_pkg::CTL_RESTART]) |=> $stable(prop_reg))
      else $error("property changed without restart");
   a_invalid_idle: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == PSS_IDLE && gt_reg == pss_pkg::GT_INVALID |=> st_reg == PSS_IDLE)
      else $error("invalid entry started");
   a_adv_pulse: assert property (@(posedge clk) disable iff (!rstn)
      st_reg == PSS_WAIT && cond_ok |=> step_advance && st_reg == PSS_IDLE ##1 !step_advance)
      else $error("advance not issued");
endmodule
`default_nettype wire

// ===== tb/pss_step_pin.sv
// Partner model: the outside switch that drives the step pin.
// Assumes the bench asks for a level on clk; the pin is always driven.
`default_nettype none
module pss_step_pin (
   // Clock
   input wire logic clk,
   // Level asked for by the bench
   input wire logic want_level,
   // Step pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin starts low so the synchroniser never sees an unknown
   initial pin = 1'b0;
   // Pin follows the request one edge late, like a contact behind a cable
   always @(posedge clk) begin
      pin <= want_level;
   end
endmodule
`default_nettype wire

// ===== tb/pss_seq_top_bench.sv
// Self-checking bench for the position step sequencer.
// Assumes the register port and step pin of pss_seq_top, and the step pin partner.
`default_nettype none
module pss_seq_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic want_level = 1'b0;
   logic pin;
   logic entry_active, entry_absolute, step_advance;
   logic signed [31:0] entry_target;
   logic [15:0] entry_speed;
   logic [3:0] entry_mode;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   int phase;
   int cnt;
   logic [31:0] d;
   logic signed [31:0] tgt;
   // Clock at 40 MHz
   always #12.5 clk = ~clk;
   // Short delay unit keeps delay conditions cheap to run
   pss_seq_top #(.UNIT_CYC(4)) pss_seq_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .position_step_input(pin), .entry_active(entry_active), .entry_absolute(entry_absolute),
      .entry_target(entry_target), .entry_speed(entry_speed), .entry_mode(entry_mode),
      .step_advance(step_advance));
   pss_step_pin pss_step_pin_inst (.clk(clk), .want_level(want_level), .pin(pin));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One write cycle; ends at the edge that lowers the strobe
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data is taken at the edge closing the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
   // Sampling at the edge sees the settled value of the cycle just ended
   task automatic watch(input int n, input int ph);
      repeat (n) begin
         @(posedge clk);
         if (phase < 0 && step_advance === 1'b1) phase = ph;
      end
   endtask
   // Arm a condition with the pin at p0, then flip the pin twice
   task automatic cond_case(input logic [15:0] prop, input logic [15:0] v1, input logic [15:0] v2,
                            input logic p0, input int exp_ph);
      wr(pss_pkg::OFF_STEP_PROP, {16'h0, prop});
      wr(pss_pkg::OFF_COND1_VAL, {16'h0, v1});
      wr(pss_pkg::OFF_COND2_VAL, {16'h0, v2});
      want_level <= p0;
      wr(pss_pkg::OFF_CONTROL, 32'h1);
      repeat (6) @(posedge clk);
      wr(pss_pkg::OFF_CONTROL, 32'h6);
      phase = -1;
      watch(14, 0);
      want_level <= ~p0;
      watch(10, 1);
      want_level <= p0;
      watch(10, 2);
      check("advance phase", 32'(phase), 32'(exp_ph));
   endtask
   // Hang guard: the whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(pss_pkg::OFF_SPEED, d);
      check("speed reset", d, 32'h64);
      rd(pss_pkg::OFF_STEP_PROP, d);
      check("property reset", d, 32'h0);
      rd(pss_pkg::OFF_POS_LOW, d);
      check("low reset", d, 32'h0);
      rd(pss_pkg::OFF_GROUP_TYPE, d);
      check("type reset", d, 32'h0);
      check("target reset", entry_target, 32'h0);
      check("active speed reset", {16'h0, entry_speed}, 32'h64);
      // Out-of-range writes are held to the limits
      wr(pss_pkg::OFF_POS_LOW, 32'h2ee0);
      rd(pss_pkg::OFF_POS_LOW, d);
      check("low clamp high", {16'h0, d[15:0]}, 32'h270f);
      wr(pss_pkg::OFF_POS_LOW, 32'hd120);
      rd(pss_pkg::OFF_POS_LOW, d);
      check("low clamp low", {16'h0, d[15:0]}, 32'hd8f1);
      wr(pss_pkg::OFF_SPEED, 32'h1b58);
      rd(pss_pkg::OFF_SPEED, d);
      check("speed clamp", {16'h0, d[15:0]}, 32'h1770);
      rd(4'hf, d);
      check("unmapped read", d, 32'h0);
      // New settings stay hidden until restart
      wr(pss_pkg::OFF_POS_LOW, 32'h04d2);
      wr(pss_pkg::OFF_POS_HIGH, 32'hfffe);
      wr(pss_pkg::OFF_SPEED, 32'h05dc);
      repeat (3) @(posedge clk);
      check("target before restart", entry_target, 32'h0);
      wr(pss_pkg::OFF_CONTROL, 32'h1);
      repeat (3) @(posedge clk);
      tgt = -2 * 10000 + 1234;
      check("target combined", entry_target, tgt);
      check("active speed", {16'h0, entry_speed}, 32'h05dc);
      rd(pss_pkg::OFF_TARGET_LO, d);
      check("target low half", {16'h0, d[15:0]}, {16'h0, tgt[15:0]});
      rd(pss_pkg::OFF_TARGET_HI, d);
      check("target high half", {16'h0, d[15:0]}, {16'h0, tgt[31:16]});
      // Invalid group refuses start; relative group runs
      wr(pss_pkg::OFF_CONTROL, 32'h2);
      repeat (3) @(posedge clk);
      check("invalid group idle", {31'h0, entry_active}, 32'h0);
      wr(pss_pkg::OFF_GROUP_TYPE, 32'h2);
      wr(pss_pkg::OFF_CONTROL, 32'h1);
      repeat (3) @(posedge clk);
      wr(pss_pkg::OFF_CONTROL, 32'h2);
      repeat (2) @(posedge clk);
      check("relative active", {31'h0, entry_active}, 32'h1);
      check("relative kind", {31'h0, entry_absolute}, 32'h0);
      wr(pss_pkg::OFF_CONTROL, 32'h4);
      phase = -1;
      watch(12, 0);
      check("relative advance", 32'(phase), 32'h0);
      // Idle, motion done kept, both conditions disarmed, pin low
      rd(pss_pkg::OFF_STATUS, d);
      check("status after advance", d, 32'h9);
      wr(pss_pkg::OFF_GROUP_TYPE, 32'h1);
      // Unconditional with mode digit 5
      cond_case(16'h5000, 16'h0, 16'h0, 1'b0, 0);
      check("mode digit", {28'h0, entry_mode}, 32'h5);
      check("absolute kind", {31'h0, entry_absolute}, 32'h1);
      // Edge codes: the wrong edge comes first where there is one
      cond_case(16'h0002, 16'h0, 16'h0, 1'b1, 2);
      cond_case(16'h0002, 16'h1, 16'h0, 1'b0, 2);
      cond_case(16'h0002, 16'h2, 16'h0, 1'b1, 1);
      // Level codes
      cond_case(16'h0003, 16'h3, 16'h0, 1'b0, 1);
      cond_case(16'h0003, 16'h3, 16'h0, 1'b1, 0);
      cond_case(16'h0003, 16'h4, 16'h0, 1'b1, 1);
      // Joins: AND waits for the level, OR takes the edge before a long delay
      cond_case(16'h0130, 16'h0, 16'h4, 1'b1, 1);
      cond_case(16'h0221, 16'd1000, 16'h0, 1'b0, 1);
      // Delay of 5 units at 4 cycles each
      wr(pss_pkg::OFF_STEP_PROP, 32'h1);
      wr(pss_pkg::OFF_COND1_VAL, 32'h5);
      wr(pss_pkg::OFF_CONTROL, 32'h1);
      repeat (3) @(posedge clk);
      wr(pss_pkg::OFF_CONTROL, 32'h6);
      cnt = 0;
      while (step_advance !== 1'b1 && cnt < 60) begin
         @(posedge clk);
         cnt++;
      end
      check("delay not early", 32'(cnt >= 20), 32'h1);
      check("delay not late", 32'(cnt <= 30), 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
